// *** sahi_host_model.sv ***
// Host-side partner: comparator front end and host-made clocks
`timescale 1ns/1ps
`default_nettype none
module sahi_host_model (
  input wire logic [sahi_pkg::RES_MSB:0] dac_code,
  input wire logic [sahi_pkg::RES_MSB:0] target,
  input wire logic shift_en,
  input wire logic ext_en,
  output logic comparator_in,
  output logic shift_clock_in,
  output logic ext_clk
);
  // Keeps the trial bit while the trial code does not pass the input
  assign comparator_in = dac_code <= target;
  // Idles low between frames; 32 ns, off the system clock grid
  initial begin
    shift_clock_in = 1'b0;
    #3;
    forever #16 shift_clock_in = shift_en & ~shift_clock_in;
  end
  // 4 MHz, inside the allowed band; stopped when not selected
  initial begin
    ext_clk = 1'b0;
    forever #125 ext_clk = ext_en & ~ext_clk;
  end
endmodule
`default_nettype wire

// *** sahi_pkg.sv ***
// Constants, types and layout shared by the converter host interface
package sahi_pkg;
  localparam int RES_W = 14;
  localparam int RES_MSB = RES_W - 1;
  localparam int CLK_NS = 10;
  localparam int INT_HALF_NS = 125;
  localparam int INT_HALF_CYC = (INT_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATA_LEAD_NS = 20;
  localparam int DATA_LEAD_CYC = (DATA_LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_BIPOLAR_BIT = 1;
  localparam logic CTRL_BIPOLAR_RST = 1'b0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_NAP_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  localparam int ST_SERIAL_BIT = 3;
  localparam int ST_EXTCLK_BIT = 4;
  localparam int ST_IGNORED_BIT = 5;
  localparam int PIN_EXT_SEL = 0;
  localparam int PIN_SER_DOUT = 1;
  localparam int PIN_CLK_OUT = 2;
  localparam int PIN_SHIFT_CLK = 3;
  localparam int PIN_EXT_CLK = 4;
  localparam logic [4:0] CTL_SYNC_RST = 5'h0f;
  localparam int COUNT_W = 16;
  typedef enum logic [1:0] {PWR_RUN, PWR_NAP, PWR_SLEEP} sahi_pwr_t;
  typedef enum logic [2:0] {
    CV_IDLE, CV_CLEAR, CV_TRIAL, CV_DECIDE, CV_LATCH, CV_LEAD
  } sahi_conv_t;
endpackage

// *** sahi_result_if.sv ***
// Result word and its change toggle, crossing to the shift clock domain
`timescale 1ns/1ps
`default_nettype none
interface sahi_result_if;
  logic [sahi_pkg::RES_MSB:0] word;
  logic toggle;
  modport src (output word, output toggle);
  modport dst (input word, input toggle);
endinterface
`default_nettype wire

// *** sahi_ser_tx.sv ***
// Serial result shifter on the host shift clock
`timescale 1ns/1ps
`default_nettype none
module sahi_ser_tx (
  input wire logic sclk,
  input wire logic rst_n,
  sahi_result_if.dst res,
  output logic sdo
);
  logic tog_meta_r;
  logic tog_sync_r;
  logic tog_seen_r;
  logic [sahi_pkg::RES_MSB:0] shift_r;

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      tog_meta_r <= 1'b0;
      tog_sync_r <= 1'b0;
    end else begin
      tog_meta_r <= res.toggle;
      tog_sync_r <= tog_meta_r;
    end
  end

  // Word is held steady by the sender while the toggle travels
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      tog_seen_r <= 1'b0;
      shift_r <= '0;
      sdo <= 1'b0;
    end else if (tog_sync_r != tog_seen_r) begin
      tog_seen_r <= tog_sync_r;
      shift_r <= res.word;
      sdo <= res.word[sahi_pkg::RES_MSB];
    end else begin
      shift_r <= {shift_r[sahi_pkg::RES_MSB-1:0], 1'b0};
      sdo <= shift_r[sahi_pkg::RES_MSB-1];
    end
  end
endmodule
`default_nettype wire

// *** sahi_sync.sv ***
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module sahi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST;
      q <= RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** sahi_top.sv ***
// Converter control, pin interface and APB registers
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sahi_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sahi_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_select_n,
  input wire logic conversion_start_n,
  input wire logic read_strobe_n,
  input wire logic power_down_n,
  input wire logic output_format_sel,
  input wire logic comparator_in,
  input wire logic [sahi_pkg::RES_MSB:0] data_in,
  input wire logic shift_clock_in,
  output logic busy_n,
  output logic [sahi_pkg::RES_MSB:0] data_out,
  output logic [sahi_pkg::RES_MSB:0] data_oe,
  output logic [sahi_pkg::RES_MSB:0] dac_code,
  output logic serial_data_out,
  output logic conv_clock_out,
  output logic nap_mode,
  output logic sleep_mode
);
  logic [4:0] ctl_raw;
  logic [4:0] ctl_sync;
  logic [2:0] aux_raw;
  logic [2:0] aux_sync;
  logic cs_n_s;
  logic cst_n_s;
  logic rd_n_s;
  logic pd_n_s;
  logic serial_s;
  logic comp_s;
  logic ext_clk_s;
  logic ext_sel_s;
  logic cst_prev_r;
  logic ext_prev_r;
  logic [7:0] half_cnt_r;
  logic int_clk_r;
  logic int_tick;
  logic ext_tick;
  logic conv_tick;
  logic use_ext;
  sahi_pkg::sahi_pwr_t pwr_r;
  sahi_pkg::sahi_conv_t cv_r;
  logic [sahi_pkg::RES_MSB:0] sar_r;
  logic [3:0] bit_r;
  logic [1:0] lead_cnt_r;
  logic [sahi_pkg::RES_MSB:0] result_r;
  logic res_tog_r;
  logic bipolar_r;
  logic soft_start_r;
  logic ignored_r;
  logic [sahi_pkg::COUNT_W-1:0] count_r;
  logic pin_start;
  logic start_req;
  logic setup_ph;
  logic access_ph;
  logic wr_ctrl;
  logic wr_status;
  logic [31:0] rd_val;
  logic rd_hit;
  sahi_result_if res_if ();

  // Pin inputs other than the shift clock pass two flops before any logic looks at them
  assign ctl_raw = {output_format_sel, power_down_n, read_strobe_n,
                    conversion_start_n, chip_select_n};
  assign aux_raw = {comparator_in, data_in[sahi_pkg::PIN_EXT_CLK],
                    data_in[sahi_pkg::PIN_EXT_SEL]};

  sahi_sync #(.W(5), .RST(sahi_pkg::CTL_SYNC_RST)) u_sync_ctl (
    .clk(pclk),
    .rst_n(presetn),
    .d(ctl_raw),
    .q(ctl_sync)
  );

  sahi_sync #(.W(3), .RST(3'h0)) u_sync_aux (
    .clk(pclk),
    .rst_n(presetn),
    .d(aux_raw),
    .q(aux_sync)
  );

  assign cs_n_s = ctl_sync[0];
  assign cst_n_s = ctl_sync[1];
  assign rd_n_s = ctl_sync[2];
  assign pd_n_s = ctl_sync[3];
  assign serial_s = ctl_sync[4];
  assign ext_sel_s = aux_sync[0];
  assign ext_clk_s = aux_sync[1];
  assign comp_s = aux_sync[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cst_prev_r <= 1'b1;
      ext_prev_r <= 1'b0;
    end else begin
      cst_prev_r <= cst_n_s;
      ext_prev_r <= ext_clk_s;
    end
  end

  // Internal conversion clock, a divided copy of pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_r <= 8'h00;
      int_clk_r <= 1'b0;
    end else if (half_cnt_r == 8'(sahi_pkg::INT_HALF_CYC - 1)) begin
      half_cnt_r <= 8'h00;
      int_clk_r <= ~int_clk_r;
    end else begin
      half_cnt_r <= half_cnt_r + 8'h01;
    end
  end

  assign int_tick = !int_clk_r &&
                    (half_cnt_r == 8'(sahi_pkg::INT_HALF_CYC - 1));
  assign ext_tick = ext_clk_s && !ext_prev_r;
  // External clock only counts in serial mode, where its pin exists
  assign use_ext = serial_s && ext_sel_s;
  assign conv_tick = use_ext ? ext_tick : int_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_clock_out <= 1'b0;
    end else if (serial_s) begin
      conv_clock_out <= use_ext ? ext_clk_s : int_clk_r;
    end else begin
      conv_clock_out <= 1'b0;
    end
  end

  // Shutdown choice is taken from the select level as power drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r <= sahi_pkg::PWR_RUN;
    end else begin
      case (pwr_r)
        sahi_pkg::PWR_RUN: begin
          if (!pd_n_s) begin
            pwr_r <= cs_n_s ? sahi_pkg::PWR_SLEEP : sahi_pkg::PWR_NAP;
          end
        end
        sahi_pkg::PWR_NAP, sahi_pkg::PWR_SLEEP: begin
          if (pd_n_s) begin
            pwr_r <= sahi_pkg::PWR_RUN;
          end
        end
        default: pwr_r <= sahi_pkg::PWR_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nap_mode <= 1'b0;
      sleep_mode <= 1'b0;
    end else begin
      nap_mode <= (pwr_r == sahi_pkg::PWR_NAP);
      sleep_mode <= (pwr_r == sahi_pkg::PWR_SLEEP);
    end
  end

  assign pin_start = !cs_n_s && cst_prev_r && !cst_n_s;
  assign start_req = (pin_start || soft_start_r) &&
                     (pwr_r == sahi_pkg::PWR_RUN);

  // Successive approximation sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cv_r <= sahi_pkg::CV_IDLE;
      sar_r <= '0;
      bit_r <= 4'h0;
      lead_cnt_r <= 2'h0;
    end else if (pwr_r != sahi_pkg::PWR_RUN) begin
      cv_r <= sahi_pkg::CV_IDLE;
    end else begin
      case (cv_r)
        sahi_pkg::CV_IDLE: begin
          if (start_req) begin
            cv_r <= sahi_pkg::CV_CLEAR;
          end
        end
        sahi_pkg::CV_CLEAR: begin
          sar_r <= '0;
          bit_r <= 4'(sahi_pkg::RES_MSB);
          cv_r <= sahi_pkg::CV_TRIAL;
        end
        sahi_pkg::CV_TRIAL: begin
          if (conv_tick) begin
            sar_r[bit_r] <= 1'b1;
            cv_r <= sahi_pkg::CV_DECIDE;
          end
        end
        sahi_pkg::CV_DECIDE: begin
          if (conv_tick) begin
            sar_r[bit_r] <= comp_s;
            if (bit_r == 4'h0) begin
              cv_r <= sahi_pkg::CV_LATCH;
            end else begin
              bit_r <= bit_r - 4'h1;
              cv_r <= sahi_pkg::CV_TRIAL;
            end
          end
        end
        sahi_pkg::CV_LATCH: begin
          lead_cnt_r <= 2'h0;
          cv_r <= sahi_pkg::CV_LEAD;
        end
        sahi_pkg::CV_LEAD: begin
          if (lead_cnt_r == 2'(sahi_pkg::DATA_LEAD_CYC - 1)) begin
            cv_r <= sahi_pkg::CV_IDLE;
          end else begin
            lead_cnt_r <= lead_cnt_r + 2'h1;
          end
        end
        default: cv_r <= sahi_pkg::CV_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_code <= '0;
    end else begin
      dac_code <= sar_r;
    end
  end

  // Busy rises after the lead time that follows the latch, or early when power drops mid-conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_n <= 1'b1;
    end else if (cv_r == sahi_pkg::CV_IDLE && start_req &&
                 pwr_r == sahi_pkg::PWR_RUN) begin
      busy_n <= 1'b0;
    end else if (cv_r == sahi_pkg::CV_IDLE) begin
      busy_n <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= '0;
      res_tog_r <= 1'b0;
      count_r <= '0;
    end else if (cv_r == sahi_pkg::CV_LATCH) begin
      result_r <= bipolar_r ?
        {~sar_r[sahi_pkg::RES_MSB], sar_r[sahi_pkg::RES_MSB-1:0]} :
        sar_r;
      res_tog_r <= ~res_tog_r;
      count_r <= count_r + 16'h0001;
    end
  end

  // Pin starts that arrive mid-conversion are dropped but remembered; register starts are only dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ignored_r <= 1'b0;
    end else if (pin_start && cv_r != sahi_pkg::CV_IDLE) begin
      ignored_r <= 1'b1;
    end else if (wr_status && pwdata[sahi_pkg::ST_IGNORED_BIT]) begin
      ignored_r <= 1'b0;
    end
  end

  // Result pins: parallel word under read strobe, or serial roles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= '0;
      data_oe <= '0;
    end else if (serial_s) begin
      data_out <= '0;
      data_oe <= '0;
      data_oe[sahi_pkg::PIN_SER_DOUT] <= 1'b1;
      data_oe[sahi_pkg::PIN_CLK_OUT] <= 1'b1;
    end else begin
      data_out <= result_r;
      data_oe <= {sahi_pkg::RES_W{!rd_n_s && !cs_n_s}};
    end
  end

  assign res_if.word = result_r;
  assign res_if.toggle = res_tog_r;

  sahi_ser_tx u_ser_tx (
    .sclk(shift_clock_in),
    .rst_n(presetn),
    .res(res_if.dst),
    .sdo(serial_data_out)
  );

  // APB slave: answer is ready in the first access cycle
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable && pready;
  assign wr_ctrl = access_ph && pwrite && !pslverr &&
                   paddr == sahi_pkg::OFS_CTRL;
  assign wr_status = access_ph && pwrite && !pslverr &&
                     paddr == sahi_pkg::OFS_STATUS;

  always_comb begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      sahi_pkg::OFS_CTRL: begin
        rd_val[sahi_pkg::CTRL_BIPOLAR_BIT] = bipolar_r;
      end
      sahi_pkg::OFS_STATUS: begin
        rd_val[sahi_pkg::ST_BUSY_BIT] = !busy_n;
        rd_val[sahi_pkg::ST_NAP_BIT] = nap_mode;
        rd_val[sahi_pkg::ST_SLEEP_BIT] = sleep_mode;
        rd_val[sahi_pkg::ST_SERIAL_BIT] = serial_s;
        rd_val[sahi_pkg::ST_EXTCLK_BIT] = use_ext;
        rd_val[sahi_pkg::ST_IGNORED_BIT] = ignored_r;
      end
      sahi_pkg::OFS_RESULT: begin
        rd_val[sahi_pkg::RES_MSB:0] = result_r;
      end
      sahi_pkg::OFS_COUNT: begin
        rd_val[sahi_pkg::COUNT_W-1:0] = count_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup_ph) begin
      pready <= 1'b1;
      pslverr <= !rd_hit;
      prdata <= pwrite ? 32'h00000000 : rd_val;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bipolar_r <= sahi_pkg::CTRL_BIPOLAR_RST;
      soft_start_r <= 1'b0;
    end else begin
      soft_start_r <= wr_ctrl && pwdata[sahi_pkg::CTRL_START_BIT];
      if (wr_ctrl) begin
        bipolar_r <= pwdata[sahi_pkg::CTRL_BIPOLAR_BIT];
      end
    end
  end
endmodule
`default_nettype wire

// *** sahi_top_properties.sv ***
// Port-level assertions for the converter host interface
`timescale 1ns/1ps
`default_nettype none
module sahi_top_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [sahi_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chip_select_n,
  input wire logic conversion_start_n,
  input wire logic read_strobe_n,
  input wire logic power_down_n,
  input wire logic output_format_sel,
  input wire logic busy_n,
  input wire logic [sahi_pkg::RES_MSB:0] data_out,
  input wire logic [sahi_pkg::RES_MSB:0] data_oe,
  input wire logic nap_mode,
  input wire logic sleep_mode,
  input wire logic [sahi_pkg::RES_MSB:0] data_in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [10:0] low_cnt;
  // Saturates so a stuck busy still trips the bound
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt <= 11'h000;
    else if (busy_n) low_cnt <= 11'h000;
    else if (low_cnt != 11'h7ff) low_cnt <= low_cnt + 11'h001;
  end
  sequence s_start_req;
    $fell(conversion_start_n) && !chip_select_n && busy_n;
  endsequence
  sequence s_pins_ready;
    !$past(chip_select_n, 3) && $past(power_down_n, 3) && !nap_mode
    && !sleep_mode;
  endsequence
  chk_busy_start: assert property (
    s_start_req ##0 s_pins_ready |-> ##[1:8] !busy_n)
    else $error("busy did not follow a selected start");
  chk_start_ignored: assert property (
    $fell(conversion_start_n) && chip_select_n && $past(chip_select_n, 3)
    && busy_n |=> busy_n [*6])
    else $error("start taken without select");
  // A slow host clock may legally stretch a conversion, so bound internal only
  chk_busy_bound: assert property (
    !busy_n && !(output_format_sel && data_in[sahi_pkg::PIN_EXT_SEL])
    |-> low_cnt < 11'h4b0)
    else $error("conversion overran");
  chk_busy_full: assert property (
    $rose(busy_n) && power_down_n && $past(power_down_n, 4)
    |-> low_cnt > 11'h12c)
    else $error("conversion ended early");
  chk_data_lead: assert property (
    $changed(data_out) && !output_format_sel && !$past(output_format_sel, 6)
    |-> !busy_n ##1 !busy_n)
    else $error("result changed too close to busy release");
  chk_oe_source: assert property (
    data_oe[13] |-> !$past(read_strobe_n, 3) && !$past(chip_select_n, 3))
    else $error("result pins driven without read and select");
  chk_oe_serial: assert property (
    output_format_sel [*7] |-> data_oe == 14'h0006)
    else $error("serial pin drivers wrong");
  chk_shutdown_mode: assert property (
    $fell(power_down_n) && !nap_mode && !sleep_mode |->
    ##[2:6] nap_mode == !chip_select_n && sleep_mode == chip_select_n)
    else $error("wrong shutdown state");
  chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  chk_apb_error: assert property (psel && !penable && paddr > 8'h0c |=> pslverr)
    else $error("unmapped access not refused");
endmodule
bind sahi_top sahi_top_properties u_props (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .chip_select_n, .conversion_start_n,
  .read_strobe_n, .power_down_n, .output_format_sel, .busy_n, .data_out,
  .data_oe, .nap_mode, .sleep_mode, .data_in);
`default_nettype wire

// *** tb_sar_adc_host_interface.sv ***
// Self-checking bench for the converter host interface
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_host_interface;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic chip_select_n, conversion_start_n, read_strobe_n, power_down_n;
  logic output_format_sel, comparator_in, shift_clock_in, busy_n;
  logic serial_data_out, conv_clock_out, nap_mode, sleep_mode;
  logic ext_sel, ext_clk, ext_en, shift_en;
  logic [13:0] data_out, data_oe, dac_code, target;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  sahi_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .chip_select_n, .conversion_start_n,
    .read_strobe_n, .power_down_n, .output_format_sel, .comparator_in,
    .data_in({9'h000, ext_clk, 3'h0, ext_sel}), .shift_clock_in, .busy_n,
    .data_out, .data_oe, .dac_code, .serial_data_out, .conv_clock_out,
    .nap_mode, .sleep_mode);
  sahi_host_model u_host (.dac_code, .target, .shift_en, .ext_en,
    .comparator_in, .shift_clock_in, .ext_clk);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test;
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_n !== lvl && n++ < 2000) @(posedge pclk);
    chk("busy", busy_n, lvl);
  endtask
  // Spacing keeps acquisition time and the sampling-rate ceiling
  task automatic pulse_start(input logic cs);
    repeat (100) @(posedge pclk);
    chip_select_n <= cs;
    repeat (5) @(posedge pclk);
    conversion_start_n <= 1'b0;
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h04, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", rd, 32'h2);
    apb(1'b1, 8'h40, 32'h2);
    chk("err", err, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk("err", err, 1'b1);
    chk("rdata", rd, 32'h0);
  endtask
  task automatic t_parallel(input logic [13:0] t, input logic bip);
    logic [31:0] exp;
    int n;
    exp = {18'h0, t ^ {bip, 13'h0}};
    target <= t;
    apb(1'b1, 8'h00, {30'h0, bip, 1'b0});
    pulse_start(1'b0);
    n = 0;
    while (dac_code !== 14'h0 && n++ < 50) @(posedge pclk);
    while (dac_code === 14'h0 && n++ < 100) @(posedge pclk);
    chk("dac", dac_code, 32'h2000);
    @(posedge pclk);
    conversion_start_n <= 1'b1;
    pulse_start(1'b0);
    repeat (5) @(posedge pclk);
    conversion_start_n <= 1'b1;
    chk("busy", busy_n, 1'b0);
    wait_busy(1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk("result", rd, exp);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", rd, 32'h20);
    apb(1'b1, 8'h04, 32'h20);
    read_strobe_n <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("oe", data_oe, 32'h3fff);
    chk("dout", data_out, exp);
    read_strobe_n <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("oe", data_oe, 32'h0);
  endtask
  task automatic t_ignore;
    pulse_start(1'b1);
    repeat (5) @(posedge pclk);
    conversion_start_n <= 1'b1;
    read_strobe_n <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("busy", busy_n, 1'b1);
    chk("oe", data_oe, 32'h0);
    read_strobe_n <= 1'b1;
    chip_select_n <= 1'b0;
  endtask
  task automatic t_shutdown(input logic cs);
    @(posedge pclk);
    chip_select_n <= cs;
    repeat (5) @(posedge pclk);
    power_down_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("nap", nap_mode, !cs);
    chk("sleep", sleep_mode, cs);
    power_down_n <= 1'b1;
    repeat (60) @(posedge pclk);
    chip_select_n <= 1'b0;
  endtask
  task automatic t_serial(input logic ext, input logic [13:0] t);
    logic [13:0] got;
    int n;
    apb(1'b1, 8'h00, 32'h0);
    output_format_sel <= 1'b1;
    ext_sel <= ext;
    target <= t;
    n = 0;
    // The external clock is held off here, so only the internal one toggles
    repeat (200) begin
      @(posedge pclk);
      if (conv_clock_out === 1'b1) n++;
    end
    chk("conv_clock_out", n != 0, !ext);
    chk("oe", data_oe, 32'h6);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", rd, {27'h0, ext, 4'h8});
    ext_en <= ext;
    pulse_start(1'b0);
    repeat (5) @(posedge pclk);
    conversion_start_n <= 1'b1;
    wait_busy(1'b0);
    wait_busy(1'b1);
    shift_en <= 1'b1;
    n = 0;
    @(negedge shift_clock_in);
    while (serial_data_out !== 1'b1 && n++ < 10) @(negedge shift_clock_in);
    got = {serial_data_out, 13'h0};
    for (int i = 12; i >= 0; i--) begin
      @(negedge shift_clock_in);
      got[i] = serial_data_out;
    end
    chk("serial", got, t);
    @(posedge pclk);
    shift_en <= 1'b0;
    ext_en <= 1'b0;
    output_format_sel <= 1'b0;
  endtask
  // Register start needs no pin edge; runs last so serial toggles stay paired
  task automatic t_soft_start;
    repeat (100) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h1);
    wait_busy(1'b0);
    wait_busy(1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk("result", rd, 32'h25c3);
    apb(1'b0, 8'h0c, 32'h0);
    chk("count", rd, 32'h5);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {chip_select_n, conversion_start_n, read_strobe_n, power_down_n} = 4'hf;
    {output_format_sel, ext_sel, ext_en, shift_en} = 4'h0;
    target = 14'h0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_parallel(14'h2a5c, 1'b0);
    t_parallel(14'h1733, 1'b1);
    t_ignore;
    t_shutdown(1'b0);
    t_shutdown(1'b1);
    t_serial(1'b0, 14'h3a96);
    t_serial(1'b1, 14'h25c3);
    t_soft_start;
    end_of_test;
  end
endmodule
`default_nettype wire
